//--- src/fcei_defs.svh
// Offsets, field positions and reset values of the error flag registers
`ifndef FCEI_DEFS_SVH
`define FCEI_DEFS_SVH

`define FCEI_ADDR_W          8
`define FCEI_DATA_W          8

// Register offsets
`define FCEI_OFS_TOP         8'h69
`define FCEI_OFS_SERIAL      8'h6a
`define FCEI_OFS_READBACK    8'h6b
`define FCEI_OFS_MONITOR     8'h6c

`define FCEI_RESET_VAL       8'h00
`define FCEI_ZERO_BYTE       8'h00

// Top-level error register fields
`define FCEI_TOP_WATCHDOG    7
`define FCEI_TOP_MONITOR     6
`define FCEI_TOP_READBACK    5
`define FCEI_TOP_SERIAL      4
`define FCEI_TOP_PROC_PWR    3
`define FCEI_TOP_CTRL_PWR    2
`define FCEI_TOP_ORDERLY     1
`define FCEI_TOP_IMMEDIATE   0

// Serial error register fields
`define FCEI_SER_P2_ADDR     7
`define FCEI_SER_P2_CRC      5
`define FCEI_SER_P1_ADDR     3
`define FCEI_SER_P1_CRC      1
`define FCEI_SER_FRAME       0
`define FCEI_SER_RSVD_MASK   8'h54

// Pin readback register fields
`define FCEI_RB_PROC_RST     3
`define FCEI_RB_ENABLE_DRIVE_OUTPUT       0
`define FCEI_RB_RSVD_MASK    8'hf6

// Error monitor register fields
`define FCEI_MON_RESET       5
`define FCEI_MON_FAIL        4
`define FCEI_MON_PIN         3
`define FCEI_MON_RSVD_MASK   8'hc7

`endif

//--- src/fcei_pkg.sv
// Types shared by the error flag block
package fcei_pkg;
   typedef logic [7:0] fcei_byte_t;
   typedef logic [7:0] fcei_addr_t;
endpackage

//--- src/fcei_w1c_bit.sv
// One latched flag: set by a hardware event, cleared by writing one
module fcei_w1c_bit
   import fcei_pkg::*;
(
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   input  wire logic ce_i,
   // Control
   input  wire logic set_i,
   input  wire logic clr_i,
   // State
   output logic      flag_o
);

   logic flag_r;

   // Set outranks clear so an event in the clearing cycle is kept
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_r <= 1'b0;
      end else if (ce_i) begin
         flag_r <= set_i | (flag_r & ~clr_i);
      end
   end

   assign flag_o = flag_r;

endmodule // fcei_w1c_bit

//--- src/fcei_rsvd_reg.sv
// Plain read/write storage for the reserved bits of one register
`include "fcei_defs.svh"

module fcei_rsvd_reg
   import fcei_pkg::*;
#(
   parameter fcei_byte_t MASK = 8'hff
)
(
   // Clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic       ce_i,
   // Write side
   input  wire logic       wr_i,
   input  wire fcei_byte_t wdata_i,
   // Stored value, non-reserved bits read as zero
   output fcei_byte_t      q_o
);

   fcei_byte_t bits_r;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bits_r <= `FCEI_RESET_VAL;
      end else if (ce_i && wr_i) begin
         bits_r <= wdata_i & MASK;
      end
   end

   assign q_o = bits_r;

endmodule // fcei_rsvd_reg

//--- src/fcei_top.sv
// Top-level, serial-port, pin readback and error monitor flag registers with their interrupt output
//
// Contract
// - Top bit 7 read-only, set while any watchdog reset/fail/long-window flag is set.
// - Top bit 6 read-only, set while any error monitor flag bit is set (reserved bits ignored).
// - Top bit 5 read-only, set while any pin readback flag bit is set (reserved bits ignored).
// - Top bit 4 read-only, set while any serial error flag bit is set (reserved bits ignored).
// - Top bit 3 latches processor power fault; cleared by writing one.
// - Top bit 2 latches controller power fault; cleared by writing one.
// - Top bit 1 latches orderly shutdown until a one is written.
// - Top bit 0 latches immediate shutdown until a one is written.
// - Serial bit 7 latches second-port bad register address write; write one clears.
// - Second-port address/checksum flags interrupt only when checksum enabled and unmasked.
// - Serial bit 5 latches second-port checksum mismatch; write one clears.
// - Serial bit 3 latches primary-port bad register address write; write one clears.
// - Serial bit 1 latches primary-port checksum mismatch; write one clears.
// - Primary-port address/checksum flags interrupt only when checksum enabled and unmasked.
// - Serial bit 0 latches SPI framing fault; write one clears.
// - Readback register latches reset-output bit 3 and enable-drive bit 0, write-one-clear.
// - Monitor register latches reset bit 5, fail bit 4, pin fault bit 3.
`include "fcei_defs.svh"

module fcei_top
   import fcei_pkg::*;
(
   // Clock, reset, clock enable
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic       ce_i,
   // Register access port
   input  wire fcei_addr_t reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire fcei_byte_t reg_wdata_i,
   input  wire logic       reg_rd_i,
   output fcei_byte_t      reg_rdata_o,
   // Watchdog flag levels
   input  wire logic       watchdog_reset_flag_i,
   input  wire logic       watchdog_fail_flag_i,
   input  wire logic       watchdog_long_window_flag_i,
   // Power and shutdown event pulses
   input  wire logic       processor_power_fault_i,
   input  wire logic       controller_power_fault_i,
   input  wire logic       orderly_off_i,
   input  wire logic       immediate_off_i,
   // Serial port error pulses
   input  wire logic       second_port_bad_address_i,
   input  wire logic       second_port_checksum_i,
   input  wire logic       primary_port_bad_address_i,
   input  wire logic       primary_port_checksum_i,
   input  wire logic       spi_framing_fault_i,
   // Pin readback and error monitor pulses
   input  wire logic       processor_reset_output_readback_i,
   input  wire logic       enable_drive_output_readback_i,
   input  wire logic       error_monitor_reset_i,
   input  wire logic       error_monitor_fail_i,
   input  wire logic       error_monitor_pin_i,
   // Checksum configuration
   input  wire logic       second_port_checksum_enable_i,
   input  wire logic       second_port_checksum_mask_i,
   input  wire logic       primary_port_checksum_enable_i,
   input  wire logic       primary_port_checksum_mask_i,
   // Interrupt pin
   output logic            interrupt_out_n_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   logic wr_top;
   logic wr_serial;
   logic wr_readback;
   logic wr_monitor;

   assign wr_top      = reg_wr_i && (reg_addr_i == `FCEI_OFS_TOP);
   assign wr_serial   = reg_wr_i && (reg_addr_i == `FCEI_OFS_SERIAL);
   assign wr_readback = reg_wr_i && (reg_addr_i == `FCEI_OFS_READBACK);
   assign wr_monitor  = reg_wr_i && (reg_addr_i == `FCEI_OFS_MONITOR);

   // Clear strobes: a written zero leaves a flag alone
   fcei_byte_t clr_top;
   fcei_byte_t clr_serial;
   fcei_byte_t clr_readback;
   fcei_byte_t clr_monitor;

   assign clr_top      = wr_top      ? reg_wdata_i : `FCEI_ZERO_BYTE;
   assign clr_serial   = wr_serial   ? reg_wdata_i : `FCEI_ZERO_BYTE;
   assign clr_readback = wr_readback ? reg_wdata_i : `FCEI_ZERO_BYTE;
   assign clr_monitor  = wr_monitor  ? reg_wdata_i : `FCEI_ZERO_BYTE;

   ////////////////////////////////////////////////////////////////////////////
   // Top-level latched flags

   logic processor_power_fault_flag;
   logic controller_power_fault_flag;
   logic orderly_off_flag;
   logic immediate_off_flag;

   fcei_w1c_bit u_proc_pwr (
      .mclk_i  (mclk_i), .rst_n_i (rst_n_i), .ce_i    (ce_i),
      .set_i   (processor_power_fault_i),
      .clr_i   (clr_top[`FCEI_TOP_PROC_PWR]),
      .flag_o  (processor_power_fault_flag)
   );

   fcei_w1c_bit u_ctrl_pwr (
      .mclk_i  (mclk_i), .rst_n_i (rst_n_i), .ce_i    (ce_i),
      .set_i   (controller_power_fault_i),
      .clr_i   (clr_top[`FCEI_TOP_CTRL_PWR]),
      .flag_o  (controller_power_fault_flag)
   );

   fcei_w1c_bit u_orderly (
      .mclk_i  (mclk_i), .rst_n_i (rst_n_i), .ce_i    (ce_i),
      .set_i   (orderly_off_i),
      .clr_i   (clr_top[`FCEI_TOP_ORDERLY]),
      .flag_o  (orderly_off_flag)
   );

   fcei_w1c_bit u_immediate (
      .mclk_i  (mclk_i), .rst_n_i (rst_n_i), .ce_i    (ce_i),
      .set_i   (immediate_off_i),
      .clr_i   (clr_top[`FCEI_TOP_IMMEDIATE]),
      .flag_o  (immediate_off_flag)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Serial error flags

   logic second_port_bad_address_flag;
   logic second_port_checksum_flag;
   logic primary_port_bad_address_flag;
   logic primary_port_checksum_flag;
   logic spi_framing_fault_flag;

   fcei_w1c_bit u_p2_addr (
      .mclk_i  (mclk_i), .rst_n_i (rst_n_i), .ce_i    (ce_i),
      .set_i   (second_port_bad_address_i),
      .clr_i   (clr_serial[`FCEI_SER_P2_ADDR]),
      .flag_o  (second_port_bad_address_flag)
   );

   fcei_w1c_bit u_p2_crc (
      .mclk_i  (mclk_i), .rst_n_i (rst_n_i), .ce_i    (ce_i),
      .set_i   (second_port_checksum_i),
      .clr_i   (clr_serial[`FCEI_SER_P2_CRC]),
      .flag_o  (second_port_checksum_flag)
   );

   fcei_w1c_bit u_p1_addr (
      .mclk_i  (mclk_i), .rst_n_i (rst_n_i), .ce_i    (ce_i),
      .set_i   (primary_port_bad_address_i),
      .clr_i   (clr_serial[`FCEI_SER_P1_ADDR]),
      .flag_o  (primary_port_bad_address_flag)
   );

   fcei_w1c_bit u_p1_crc (
      .mclk_i  (mclk_i), .rst_n_i (rst_n_i), .ce_i    (ce_i),
      .set_i   (primary_port_checksum_i),
      .clr_i   (clr_serial[`FCEI_SER_P1_CRC]),
      .flag_o  (primary_port_checksum_flag)
   );

   fcei_w1c_bit u_frame (
      .mclk_i  (mclk_i), .rst_n_i (rst_n_i), .ce_i    (ce_i),
      .set_i   (spi_framing_fault_i),
      .clr_i   (clr_serial[`FCEI_SER_FRAME]),
      .flag_o  (spi_framing_fault_flag)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pin readback and error monitor flags

   logic proc_reset_readback_flag;
   logic enable_drive_readback_flag;
   logic monitor_reset_flag;
   logic monitor_fail_flag;
   logic monitor_pin_flag;

   fcei_w1c_bit u_rb_rst (
      .mclk_i  (mclk_i), .rst_n_i (rst_n_i), .ce_i    (ce_i),
      .set_i   (processor_reset_output_readback_i),
      .clr_i   (clr_readback[`FCEI_RB_PROC_RST]),
      .flag_o  (proc_reset_readback_flag)
   );

   fcei_w1c_bit u_rb_drv (
      .mclk_i  (mclk_i), .rst_n_i (rst_n_i), .ce_i    (ce_i),
      .set_i   (enable_drive_output_readback_i),
      .clr_i   (clr_readback[`FCEI_RB_ENABLE_DRIVE_OUTPUT]),
      .flag_o  (enable_drive_readback_flag)
   );

   fcei_w1c_bit u_mon_rst (
      .mclk_i  (mclk_i), .rst_n_i (rst_n_i), .ce_i    (ce_i),
      .set_i   (error_monitor_reset_i),
      .clr_i   (clr_monitor[`FCEI_MON_RESET]),
      .flag_o  (monitor_reset_flag)
   );

   fcei_w1c_bit u_mon_fail (
      .mclk_i  (mclk_i), .rst_n_i (rst_n_i), .ce_i    (ce_i),
      .set_i   (error_monitor_fail_i),
      .clr_i   (clr_monitor[`FCEI_MON_FAIL]),
      .flag_o  (monitor_fail_flag)
   );

   fcei_w1c_bit u_mon_pin (
      .mclk_i  (mclk_i), .rst_n_i (rst_n_i), .ce_i    (ce_i),
      .set_i   (error_monitor_pin_i),
      .clr_i   (clr_monitor[`FCEI_MON_PIN]),
      .flag_o  (monitor_pin_flag)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Reserved storage, no effect on any flag

   fcei_byte_t rsvd_serial;
   fcei_byte_t rsvd_readback;
   fcei_byte_t rsvd_monitor;

   fcei_rsvd_reg #(.MASK(`FCEI_SER_RSVD_MASK)) u_rsvd_serial (
      .mclk_i  (mclk_i), .rst_n_i (rst_n_i), .ce_i    (ce_i),
      .wr_i    (wr_serial), .wdata_i (reg_wdata_i), .q_o     (rsvd_serial)
   );

   fcei_rsvd_reg #(.MASK(`FCEI_RB_RSVD_MASK)) u_rsvd_readback (
      .mclk_i  (mclk_i), .rst_n_i (rst_n_i), .ce_i    (ce_i),
      .wr_i    (wr_readback), .wdata_i (reg_wdata_i), .q_o     (rsvd_readback)
   );

   fcei_rsvd_reg #(.MASK(`FCEI_MON_RSVD_MASK)) u_rsvd_monitor (
      .mclk_i  (mclk_i), .rst_n_i (rst_n_i), .ce_i    (ce_i),
      .wr_i    (wr_monitor), .wdata_i (reg_wdata_i), .q_o     (rsvd_monitor)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register images and summaries

   fcei_byte_t serial_flags;
   fcei_byte_t readback_flags;
   fcei_byte_t monitor_flags;
   fcei_byte_t top_flags;

   always_comb begin
      serial_flags                     = `FCEI_ZERO_BYTE;
      serial_flags[`FCEI_SER_P2_ADDR]  = second_port_bad_address_flag;
      serial_flags[`FCEI_SER_P2_CRC]   = second_port_checksum_flag;
      serial_flags[`FCEI_SER_P1_ADDR]  = primary_port_bad_address_flag;
      serial_flags[`FCEI_SER_P1_CRC]   = primary_port_checksum_flag;
      serial_flags[`FCEI_SER_FRAME]    = spi_framing_fault_flag;
      readback_flags                   = `FCEI_ZERO_BYTE;
      readback_flags[`FCEI_RB_PROC_RST] = proc_reset_readback_flag;
      readback_flags[`FCEI_RB_ENABLE_DRIVE_OUTPUT]  = enable_drive_readback_flag;
      monitor_flags                    = `FCEI_ZERO_BYTE;
      monitor_flags[`FCEI_MON_RESET]   = monitor_reset_flag;
      monitor_flags[`FCEI_MON_FAIL]    = monitor_fail_flag;
      monitor_flags[`FCEI_MON_PIN]     = monitor_pin_flag;
   end

   // Summaries follow their sources, so writes to them have nothing to change
   always_comb begin
      top_flags = `FCEI_ZERO_BYTE;
      top_flags[`FCEI_TOP_WATCHDOG] = watchdog_reset_flag_i | watchdog_fail_flag_i
                                      | watchdog_long_window_flag_i;
      top_flags[`FCEI_TOP_MONITOR]  = (monitor_flags != `FCEI_ZERO_BYTE);
      top_flags[`FCEI_TOP_READBACK] = (readback_flags != `FCEI_ZERO_BYTE);
      top_flags[`FCEI_TOP_SERIAL]   = (serial_flags != `FCEI_ZERO_BYTE);
      top_flags[`FCEI_TOP_PROC_PWR] = processor_power_fault_flag;
      top_flags[`FCEI_TOP_CTRL_PWR] = controller_power_fault_flag;
      top_flags[`FCEI_TOP_ORDERLY]  = orderly_off_flag;
      top_flags[`FCEI_TOP_IMMEDIATE] = immediate_off_flag;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port

   fcei_byte_t rdata_r;
   fcei_byte_t rdata_nxt;

   always_comb begin
      case (reg_addr_i)
         `FCEI_OFS_TOP:      rdata_nxt = top_flags;
         `FCEI_OFS_SERIAL:   rdata_nxt = serial_flags | rsvd_serial;
         `FCEI_OFS_READBACK: rdata_nxt = readback_flags | rsvd_readback;
         `FCEI_OFS_MONITOR:  rdata_nxt = monitor_flags | rsvd_monitor;
         default:            rdata_nxt = `FCEI_ZERO_BYTE;
      endcase
   end

   // Read data holds until the next read so a slow shifter can sample it
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_r <= `FCEI_RESET_VAL;
      end else if (ce_i && reg_rd_i) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt pin

   logic second_port_irq_ok;
   logic primary_port_irq_ok;
   logic irq_any;
   logic irq_n_r;

   assign second_port_irq_ok  = second_port_checksum_enable_i & ~second_port_checksum_mask_i;
   assign primary_port_irq_ok = primary_port_checksum_enable_i & ~primary_port_checksum_mask_i;

   assign irq_any = top_flags[`FCEI_TOP_WATCHDOG]
                  | processor_power_fault_flag | controller_power_fault_flag
                  | orderly_off_flag | immediate_off_flag
                  | (monitor_flags != `FCEI_ZERO_BYTE)
                  | (readback_flags != `FCEI_ZERO_BYTE)
                  | ((second_port_bad_address_flag | second_port_checksum_flag) & second_port_irq_ok)
                  | ((primary_port_bad_address_flag | primary_port_checksum_flag) & primary_port_irq_ok)
                  | spi_framing_fault_flag;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_n_r <= 1'b1;
      end else if (ce_i) begin
         irq_n_r <= ~irq_any;
      end
   end

   assign interrupt_out_n_o = irq_n_r;

endmodule // fcei_top

//--- dv/fcei_top_sva.sv
// Port-level checks of the error flag registers and interrupt output
`include "fcei_defs.svh"
module fcei_top_sva
   import fcei_pkg::*;
(
   // Clock, reset, clock enable
   input wire logic       mclk_i,
   input wire logic       rst_n_i,
   input wire logic       ce_i,
   // Register access port
   input wire fcei_addr_t reg_addr_i,
   input wire logic       reg_wr_i,
   input wire fcei_byte_t reg_wdata_i,
   input wire logic       reg_rd_i,
   input wire fcei_byte_t reg_rdata_o,
   // Event and level sources
   input wire logic       watchdog_reset_flag_i,
   input wire logic       watchdog_fail_flag_i,
   input wire logic       watchdog_long_window_flag_i,
   input wire logic       orderly_off_i,
   input wire logic       immediate_off_i,
   input wire logic       second_port_checksum_i,
   input wire logic       primary_port_bad_address_i,
   input wire logic       spi_framing_fault_i,
   input wire logic       enable_drive_output_readback_i,
   input wire logic       error_monitor_pin_i,
   // Checksum configuration
   input wire logic       second_port_checksum_enable_i,
   input wire logic       second_port_checksum_mask_i,
   input wire logic       primary_port_checksum_enable_i,
   input wire logic       primary_port_checksum_mask_i,
   // Interrupt pin
   input wire logic       interrupt_out_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic wd_any;
   logic rd_top;
   assign wd_any = watchdog_reset_flag_i | watchdog_fail_flag_i | watchdog_long_window_flag_i;
   assign rd_top = ce_i && reg_rd_i && reg_addr_i == `FCEI_OFS_TOP;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   ////////////////////////////////////////////////////////////////////////////////
   // The event-then-read spacing of two cycles matches the host model's cadence
   wd_summary_a :
      assert property (rd_top |=> reg_rdata_o[7] == $past(wd_any)) else $error("watchdog summary wrong");
   monitor_summary_a :
      assert property ((ce_i && error_monitor_pin_i) ##2 rd_top |=> reg_rdata_o[6]) else $error("monitor summary clear");
   readback_summary_a :
      assert property ((ce_i && enable_drive_output_readback_i) ##2 rd_top |=> reg_rdata_o[5])
         else $error("readback summary clear");
   serial_summary_a :
      assert property ((ce_i && spi_framing_fault_i) ##2 rd_top |=> reg_rdata_o[4]) else $error("serial summary clear");
   set_wins_a :
      assert property ((ce_i && orderly_off_i && reg_wr_i && reg_addr_i == `FCEI_OFS_TOP && reg_wdata_i[1])
         ##2 rd_top |=> reg_rdata_o[1]) else $error("clear beat a new event");
   immediate_irq_a :
      assert property ((ce_i && immediate_off_i) ##1 ce_i |=> !interrupt_out_n_o) else $error("no interrupt");
   second_irq_a :
      assert property ((ce_i && second_port_checksum_i && second_port_checksum_enable_i && !second_port_checksum_mask_i)
         ##1 ce_i |=> !interrupt_out_n_o) else $error("second port interrupt missing");
   primary_irq_a :
      assert property ((ce_i && primary_port_bad_address_i && primary_port_checksum_enable_i
         && !primary_port_checksum_mask_i) ##1 ce_i |=> !interrupt_out_n_o) else $error("primary interrupt missing");
   unmapped_read_a :
      assert property ((ce_i && reg_rd_i && !(reg_addr_i inside {[8'h69:8'h6c]})) |=> reg_rdata_o == 8'h00)
         else $error("unmapped read not zero");
endmodule // fcei_top_sva

bind fcei_top fcei_top_sva u_sva (
   .mclk_i, .rst_n_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
   .watchdog_reset_flag_i, .watchdog_fail_flag_i, .watchdog_long_window_flag_i, .orderly_off_i, .immediate_off_i,
   .second_port_checksum_i, .primary_port_bad_address_i, .spi_framing_fault_i, .enable_drive_output_readback_i,
   .error_monitor_pin_i, .second_port_checksum_enable_i, .second_port_checksum_mask_i,
   .primary_port_checksum_enable_i, .primary_port_checksum_mask_i, .interrupt_out_n_o);

//--- dv/fcei_host_model.sv
// Host model: single-cycle register accesses launched on the falling edge
module fcei_host_model
   import fcei_pkg::*;
(
   // Clock
   input  wire logic mclk_i,
   // Register access port
   output fcei_addr_t reg_addr_o,
   output logic       reg_wr_o,
   output fcei_byte_t reg_wdata_o,
   output logic       reg_rd_o
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      reg_addr_o  = 8'h00;
      reg_wdata_o = 8'h00;
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
   end

   task automatic access(input logic wr, input fcei_addr_t a, input fcei_byte_t d);
      @(negedge mclk_i);
      reg_addr_o  = a;
      reg_wdata_o = d;
      reg_wr_o    = wr;
      reg_rd_o    = !wr;
      @(negedge mclk_i);
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      // Idle bus shows no stale value, so a sloppy decode cannot hide
      reg_addr_o  = ~a;
      reg_wdata_o = ~d;
   endtask
endmodule // fcei_host_model

//--- dv/testbench.sv
// Self-checking bench for the error flag registers and interrupt output
module testbench
   import fcei_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        mclk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        ce_i = 1'b1;
   fcei_addr_t  reg_addr;
   logic        reg_wr;
   logic        reg_rd;
   fcei_byte_t  reg_wdata;
   fcei_byte_t  reg_rdata;
   logic [13:0] ev = '0;
   logic [2:0]  wd = '0;
   logic [3:0]  cfg = 4'b1010;
   logic        irq_n;
   logic        rd_seen = 1'b0;
   fcei_byte_t  exp_q[$];
   int          mismatches = 0;
   int          tests_run = 0;
   fcei_addr_t  home [14] = '{8'h69, 8'h69, 8'h69, 8'h69, 8'h6a, 8'h6a, 8'h6a, 8'h6a, 8'h6a, 8'h6b, 8'h6b,
                             8'h6c, 8'h6c, 8'h6c};
   int          pos [14] = '{3, 2, 1, 0, 7, 5, 3, 1, 0, 3, 0, 5, 4, 3};
   fcei_byte_t  rsv [3] = '{8'h54, 8'hf6, 8'hc7};

   always #25 mclk_i = ~mclk_i;

   fcei_top DUT (
      .mclk_i, .rst_n_i, .ce_i,
      .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
      .watchdog_reset_flag_i(wd[0]), .watchdog_fail_flag_i(wd[1]), .watchdog_long_window_flag_i(wd[2]),
      .processor_power_fault_i(ev[0]), .controller_power_fault_i(ev[1]), .orderly_off_i(ev[2]),
      .immediate_off_i(ev[3]), .second_port_bad_address_i(ev[4]), .second_port_checksum_i(ev[5]),
      .primary_port_bad_address_i(ev[6]), .primary_port_checksum_i(ev[7]), .spi_framing_fault_i(ev[8]),
      .processor_reset_output_readback_i(ev[9]), .enable_drive_output_readback_i(ev[10]),
      .error_monitor_reset_i(ev[11]), .error_monitor_fail_i(ev[12]), .error_monitor_pin_i(ev[13]),
      .second_port_checksum_enable_i(cfg[3]), .second_port_checksum_mask_i(cfg[2]),
      .primary_port_checksum_enable_i(cfg[1]), .primary_port_checksum_mask_i(cfg[0]), .interrupt_out_n_o(irq_n));

   fcei_host_model host (.mclk_i, .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input fcei_byte_t seen, input fcei_byte_t expd);
      tests_run++;
      if (seen !== expd) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, expd, seen);
      end
   endtask

   task automatic summarize();
      $display("Checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic rd_chk(input fcei_addr_t a, input fcei_byte_t e);
      exp_q.push_back(e);
      host.access(1'b0, a, 8'h00);
   endtask

   task automatic fire(input int i);
      @(negedge mclk_i);
      ev[i] = 1'b1;
      @(negedge mclk_i);
      ev[i] = 1'b0;
   endtask

   // Interrupt is registered behind the flags, so give it two edges to settle
   task automatic irq_chk(input logic e);
      repeat (2) @(negedge mclk_i);
      check("interrupt_out_n", {7'h00, irq_n}, {7'h00, e});
   endtask

   function automatic fcei_byte_t top_img(input int i);
      fcei_byte_t m;
      m = 8'h00;
      if (home[i] == 8'h69) begin
         m[pos[i]] = 1'b1;
      end else begin
         m[home[i] - 8'h66] = 1'b1;
      end
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Read data is compared on the falling edge after the strobe was taken
   always @(posedge mclk_i) rd_seen <= ce_i && reg_rd;

   always @(negedge mclk_i) begin
      if (rd_seen) begin
         if (exp_q.size() == 0) begin
            check("read queue", 8'hff, 8'h00);
         end else begin
            check("read data", reg_rdata, exp_q.pop_front());
         end
      end
   end

   initial begin
      repeat (20000) @(posedge mclk_i);
      mismatches++;
      $display("MISMATCH run limit expected done seen hang");
      summarize();
   end

   initial begin
      void'($urandom(32'hd217940b));
      repeat (20) @(posedge mclk_i);
      @(negedge mclk_i);
      rst_n_i = 1'b1;
      for (int a = 8'h69; a <= 8'h6c; a++) begin
         rd_chk(8'(a), 8'h00);
      end
      irq_chk(1'b1);
      foreach (home[i]) begin
         fire(i);
         rd_chk(8'h69, top_img(i));
         rd_chk(home[i], 8'h01 << pos[i]);
         irq_chk(1'b0);
         host.access(1'b1, home[i], 8'h00);
         rd_chk(home[i], 8'h01 << pos[i]);
         host.access(1'b1, home[i], 8'h01 << pos[i]);
         rd_chk(8'h69, 8'h00);
         rd_chk(home[i], 8'h00);
         irq_chk(1'b1);
      end
      // Port errors stay visible in the summary even when kept off the pin
      for (int k = 0; k < 2; k++) begin
         cfg = k ? 4'b1111 : 4'b0000;
         for (int i = 4; i < 8; i++) begin
            fire(i);
            rd_chk(8'h69, 8'h10);
            irq_chk(1'b1);
            host.access(1'b1, home[i], 8'h01 << pos[i]);
         end
      end
      cfg = 4'b1010;
      repeat (6) begin
         wd = 3'($urandom);
         host.access(1'b1, 8'h69, 8'($urandom) & 8'hf0);
         rd_chk(8'h69, {|wd, 7'h00});
         irq_chk(~|wd);
      end
      wd = 3'h0;
      // A low clock enable must freeze the flags, so this event is lost
      ce_i = 1'b0;
      fire(3);
      ce_i = 1'b1;
      rd_chk(8'h69, 8'h00);
      irq_chk(1'b1);
      foreach (rsv[j]) begin
         host.access(1'b1, 8'(8'h6a + j), rsv[j]);
         rd_chk(8'(8'h6a + j), rsv[j]);
         rd_chk(8'h69, 8'h00);
         irq_chk(1'b1);
         host.access(1'b1, 8'(8'h6a + j), 8'h00);
      end
      fork
         host.access(1'b1, 8'h69, 8'h02);
         fire(2);
      join
      rd_chk(8'h69, 8'h02);
      host.access(1'b1, 8'h69, 8'h02);
      host.access(1'b1, 8'h68, 8'hff);
      rd_chk(8'h68, 8'h00);
      rd_chk(8'h6d, 8'h00);
      rd_chk(8'h69, 8'h00);
      for (int n = 0; n < 10 && exp_q.size() > 0; n++) begin
         @(negedge mclk_i);
      end
      check("pending reads", 8'(exp_q.size()), 8'h00);
      summarize();
   end
endmodule // testbench
